/* File: common/io_cell_pkg.sv */
// Overview of operation
// - First stage captures on both edge-clock edges
// - Shift, update, transfer registers cross domains
// - Second stage realigns words using alignment control
// - Third stage delivers data on system clock
// - Side cells offer by-one and by-two gearing
// - Seven-to-one mode shifts pin A alone; pin B is masked off
// - Top cells allow only by-one gearing
// - Side cells hold memory read-data FIFO
// - Programmable delay precedes the first-stage shift register
// - Single-rate tristate input held in SDR register
// - By-two tristate pair serialised on edge clock
// - Tristate reset clears the tristate registers
// - Strobe enable timed by strobe write clock
// - Data enable timed by shifted write clock
// - Shift, word, output and tristate registers start from configured set/clear value; delay lines, FIFO memory, counters, pointers and flags start at zero
package io_cell_pkg;

  // ************************************************************
  // Gearing modes and ratios
  // ************************************************************
  typedef enum logic [1:0] {
    GEAR_BY_ONE,
    GEAR_BY_TWO,
    GEAR_SEVEN_TO_ONE,
    GEAR_UNUSED
  } gear_mode_t;

  localparam logic [2:0] RATIO_BY_ONE = 3'h2;
  localparam logic [2:0] RATIO_BY_TWO = 3'h4;
  localparam logic [2:0] RATIO_SEVEN = 3'h7;

  // ************************************************************
  // Sizes and sampled-input positions
  // ************************************************************
  localparam int WORD_W = 7;
  localparam int SHIFT_W = 8;
  localparam int DELAY_DEPTH = 8;
  localparam int TAP_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_PTR_W = 2;
  localparam int SYNC_W = 5;
  localparam int POS_FAST_EDGE_CLOCK = 0;
  localparam int POS_STROBE_CLK = 1;
  localparam int POS_SHIFT_CLK = 2;
  localparam int POS_PIN_A = 3;
  localparam int POS_PIN_B = 4;
  localparam logic INIT_CLEARED = 1'b0;

endpackage : io_cell_pkg

/* File: hw/io_cell_ddr_gearing.sv */
`timescale 1ns/10ps
module io_cell_ddr_gearing
#(
  parameter logic INIT_VALUE = io_cell_pkg::INIT_CLEARED,
  parameter int FIFO_DEPTH = io_cell_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Link pins, asynchronous to i_clk
  input wire logic i_fast_edge_clock,
  input wire logic i_pin_a,
  input wire logic i_pin_b,
  input wire logic i_strobe_write_clock,
  input wire logic i_shifted_data_write_clock,
  // Cell configuration
  input wire logic i_cell_top,
  input wire logic [1:0] i_gear_mode,
  input wire logic [io_cell_pkg::TAP_W-1:0] i_delay_tap,
  input wire logic i_align_slip,
  input wire logic i_mem_read_en,
  // Receive side towards core
  output logic o_sys_tick,
  output logic o_rx_valid,
  output logic [io_cell_pkg::WORD_W-1:0] o_rx_word,
  input wire logic i_fifo_pop,
  output logic o_fifo_valid,
  output logic [io_cell_pkg::WORD_W-1:0] o_fifo_word,
  // Tristate block
  input wire logic i_tristate_rst,
  input wire logic i_tristate_by_two,
  input wire logic [1:0] i_tristate_control_in,
  input wire logic i_mem_write_en,
  output logic o_tristate_control_out,
  output logic o_strobe_oe,
  output logic o_data_oe
);

  localparam int W = io_cell_pkg::WORD_W;
  localparam int SW = io_cell_pkg::SYNC_W;
  localparam int DD = io_cell_pkg::DELAY_DEPTH;

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (FIFO_DEPTH != (1 << io_cell_pkg::FIFO_PTR_W))
  begin : g_bad_depth
    $error("FIFO_DEPTH must equal two to the pointer width");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] lvl;
    logic [DD-1:0] dly_a;
    logic [DD-1:0] dly_b;
    logic [io_cell_pkg::SHIFT_W-1:0] shift;
    logic [2:0] bit_cnt;
    logic slip_pend;
    logic [W-1:0] word;
    logic tick;
    logic [W-1:0] xfer;
    logic valid;
    logic [FIFO_DEPTH-1:0][W-1:0] mem;
    logic [io_cell_pkg::FIFO_PTR_W:0] wp;
    logic [io_cell_pkg::FIFO_PTR_W:0] rp;
    logic fvalid;
    logic [W-1:0] fword;
    logic ts;
    logic [1:0] ts_pair;
    logic ts_ph;
    logic strobe_oe;
    logic data_oe;
  } state_t;

  state_t q;
  state_t d;

  // Bits per system tick for each gearing mode
  function automatic logic [2:0] ratio_of(input logic [1:0] mode);
    case (mode)
      io_cell_pkg::GEAR_BY_TWO: ratio_of = io_cell_pkg::RATIO_BY_TWO;
      io_cell_pkg::GEAR_SEVEN_TO_ONE: ratio_of = io_cell_pkg::RATIO_SEVEN;
      default: ratio_of = io_cell_pkg::RATIO_BY_ONE;
    endcase
  endfunction : ratio_of

  // Keep only the low ratio bits of the shifter
  function automatic logic [W-1:0] mask_word(input logic [io_cell_pkg::SHIFT_W-1:0] sh,
                                             input logic [2:0] r);
    logic [W-1:0] m;
    m = 7'h7F >> (3'h7 - r);
    mask_word = sh[W-1:0] & m;
  endfunction : mask_word

  // ************************************************************
  // Combinational decode
  // ************************************************************
  logic [SW-1:0] settled;
  logic [SW-1:0] rise;
  logic [SW-1:0] fall;
  logic fast_edge_clock_edge;
  logic [1:0] eff_mode;
  logic [2:0] ratio;
  logic bit_a;
  logic bit_b;
  logic fifo_full;
  logic fifo_empty;

  // A change counts only when the second and third stages agree
  assign settled = ~(q.s2 ^ q.s3);
  assign rise = settled & q.s3 & ~q.lvl;
  assign fall = settled & ~q.s3 & q.lvl;
  assign fast_edge_clock_edge = rise[io_cell_pkg::POS_FAST_EDGE_CLOCK] | fall[io_cell_pkg::POS_FAST_EDGE_CLOCK];
  // Top cells are forced to by-one whatever the request
  assign eff_mode = i_cell_top ? io_cell_pkg::GEAR_BY_ONE : i_gear_mode;
  assign ratio = ratio_of(eff_mode);
  assign bit_a = q.dly_a[i_delay_tap];
  assign bit_b = q.dly_b[i_delay_tap];
  assign fifo_full = (q.wp - q.rp) == (io_cell_pkg::FIFO_PTR_W + 1)'(FIFO_DEPTH);
  assign fifo_empty = q.wp == q.rp;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    d = q;
    d.s1 = {i_pin_b, i_pin_a, i_shifted_data_write_clock, i_strobe_write_clock,
            i_fast_edge_clock};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (q.lvl & ~settled) | (q.s3 & settled);
    d.tick = 1'b0;
    d.valid = 1'b0;
    // Delay lines run on i_clk so taps give whole-cycle steps
    d.dly_a = {q.dly_a[DD-2:0], q.s3[io_cell_pkg::POS_PIN_A]};
    d.dly_b = {q.dly_b[DD-2:0], q.s3[io_cell_pkg::POS_PIN_B]};
    if (i_align_slip)
    begin
      d.slip_pend = 1'b1;
    end
    // Stage one: capture on either edge of the fast edge clock
    if (fast_edge_clock_edge)
    begin
      if (eff_mode == io_cell_pkg::GEAR_SEVEN_TO_ONE)
      begin
        // Pin B's bit is masked off, so only pin A feeds the chain
        d.shift = {q.shift[io_cell_pkg::SHIFT_W-2:0], bit_a ^ (bit_b & 1'b0)};
      end
      else
      begin
        d.shift = {q.shift[io_cell_pkg::SHIFT_W-2:0], bit_a};
      end
      if (q.bit_cnt + 3'h1 >= ratio)
      begin
        if (q.slip_pend)
        begin
          // Skip one bit so the next word starts one bit later
          d.slip_pend = i_align_slip; // A request in this same cycle stays armed
          d.bit_cnt = ratio - 3'h1;
        end
        else
        begin
          // Stage two: update the aligned word, raise the slow tick
          d.word = mask_word(d.shift, ratio);
          d.bit_cnt = 3'h0;
          d.tick = 1'b1;
        end
      end
      else
      begin
        d.bit_cnt = q.bit_cnt + 3'h1;
      end
    end
    // Stage three: transfer on the system tick
    if (q.tick)
    begin
      d.xfer = q.word;
      d.valid = 1'b1;
      if (i_mem_read_en && !i_cell_top && !fifo_full)
      begin
        d.mem[q.wp[io_cell_pkg::FIFO_PTR_W-1:0]] = q.word;
        d.wp = q.wp + 3'h1;
      end
    end
    // Memory read FIFO output stage; a full FIFO drops new words
    if (!q.fvalid || i_fifo_pop)
    begin
      d.fvalid = !fifo_empty;
      if (!fifo_empty)
      begin
        d.fword = q.mem[q.rp[io_cell_pkg::FIFO_PTR_W-1:0]];
        d.rp = q.rp + 3'h1;
      end
    end
    // Tristate: load on the slow tick, shift pair out on edge clock
    if (q.tick)
    begin
      if (i_tristate_by_two)
      begin
        d.ts_pair = i_tristate_control_in;
        d.ts_ph = 1'b0;
      end
      else
      begin
        d.ts = i_tristate_control_in[0];
      end
    end
    else if (fast_edge_clock_edge && i_tristate_by_two)
    begin
      d.ts = q.ts_pair[q.ts_ph];
      d.ts_ph = ~q.ts_ph;
    end
    // Memory write enables follow their own strobe clocks
    if (rise[io_cell_pkg::POS_STROBE_CLK])
    begin
      d.strobe_oe = i_mem_write_en;
    end
    if (rise[io_cell_pkg::POS_SHIFT_CLK])
    begin
      d.data_oe = i_mem_write_en;
    end
    if (i_tristate_rst)
    begin
      d.ts = 1'b0;
      d.ts_pair = 2'h0;
      d.ts_ph = 1'b0;
      d.strobe_oe = 1'b0;
      d.data_oe = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset loads the configured set or clear value into the shift, word, output and tristate registers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      q <= '0;
      q.shift <= {io_cell_pkg::SHIFT_W{INIT_VALUE}};
      q.word <= {W{INIT_VALUE}};
      q.xfer <= {W{INIT_VALUE}};
      q.fword <= {W{INIT_VALUE}};
      q.ts <= INIT_VALUE;
      q.ts_pair <= {2{INIT_VALUE}};
      q.strobe_oe <= INIT_VALUE;
      q.data_oe <= INIT_VALUE;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign o_sys_tick = q.tick;
  assign o_rx_valid = q.valid;
  assign o_rx_word = q.xfer;
  assign o_fifo_valid = q.fvalid;
  assign o_fifo_word = q.fword;
  assign o_tristate_control_out = q.ts;
  assign o_strobe_oe = q.strobe_oe;
  assign o_data_oe = q.data_oe;

  // ************************************************************
  // Checks
  // ************************************************************
  a_transfer_follows_tick: assert property (
    @(posedge i_clk) disable iff (i_sys_rst) q.tick |=> q.valid && q.xfer == $past(q.word))
    else $error("transfer did not follow the tick");

  a_valid_needs_tick: assert property (
    @(posedge i_clk) disable iff (i_sys_rst) q.valid |-> $past(q.tick))
    else $error("valid without a tick");

  a_tick_on_edge: assert property (
    @(posedge i_clk) disable iff (i_sys_rst) q.tick |-> $past(fast_edge_clock_edge))
    else $error("tick not caused by an edge-clock edge");

  a_top_by_one: assert property (
    @(posedge i_clk) disable iff (i_sys_rst) i_cell_top |-> ratio == io_cell_pkg::RATIO_BY_ONE)
    else $error("top cell used a wide ratio");

  a_word_width: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    q.tick && $past(ratio) == io_cell_pkg::RATIO_BY_TWO |-> q.word[W-1:4] == 3'h0)
    else $error("by-two word wider than four bits");

  a_sdr_tristate: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    q.tick && !i_tristate_by_two && !i_tristate_rst |=> q.ts == $past(i_tristate_control_in[0]))
    else $error("single-rate tristate not registered");

  a_pair_serial: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    fast_edge_clock_edge && !q.tick && i_tristate_by_two && !i_tristate_rst
    |=> q.ts == $past(q.ts_pair[q.ts_ph]) && q.ts_ph != $past(q.ts_ph))
    else $error("tristate pair not serialised");

  a_tristate_clear: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_tristate_rst |=> !q.ts && !q.strobe_oe && !q.data_oe)
    else $error("tristate reset did not clear");

  a_strobe_timing: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $changed(q.strobe_oe) && !$past(i_tristate_rst) |-> $past(rise[io_cell_pkg::POS_STROBE_CLK]))
    else $error("strobe enable moved off its clock");

  a_data_timing: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $changed(q.data_oe) && !$past(i_tristate_rst) |-> $past(rise[io_cell_pkg::POS_SHIFT_CLK]))
    else $error("data enable moved off its clock");

  a_fifo_top_off: assert property (
    @(posedge i_clk) disable iff (i_sys_rst) i_cell_top |=> q.wp == $past(q.wp))
    else $error("top cell wrote the read FIFO");

  a_init_value: assert property (
    @(posedge i_clk) $past(i_sys_rst) |-> q.xfer == {W{INIT_VALUE}} && q.ts == INIT_VALUE)
    else $error("registers not at initial value");

endmodule : io_cell_ddr_gearing

/* File: dv/link_source_model.sv */
`timescale 1ns/10ps
// ************************************************************
// Source-synchronous transmitter model
// ************************************************************
module link_source_model
(
  // Control from the bench
  input wire logic i_run,
  // Link pins towards the cell
  output logic o_edge_clk,
  output logic o_pin_a,
  output logic o_pin_b,
  output logic o_strobe_clk,
  output logic o_shift_clk,
  // Bits sent, newest in bit0
  output logic [15:0] o_hist
);
  // Clocks stand still low between frames so no stray edge reaches the cell
  initial
  begin
    {o_edge_clk, o_strobe_clk, o_shift_clk, o_pin_a, o_pin_b} = 5'h00;
    o_hist = 16'h0000;
  end
  // Data moves midway between edges, giving half a bit of margin
  always
  begin
    wait (i_run === 1'b1);
    o_pin_a = 1'($urandom);
    o_pin_b = ~o_pin_a;
    #40 o_edge_clk = 1'b1;
    o_strobe_clk = 1'b1;
    o_hist = {o_hist[14:0], o_pin_a};
    #20 o_shift_clk = 1'b1;
    #20 o_pin_a = 1'($urandom);
    o_pin_b = ~o_pin_a;
    #40 o_edge_clk = 1'b0;
    o_strobe_clk = 1'b0;
    o_hist = {o_hist[14:0], o_pin_a};
    #20 o_shift_clk = 1'b0;
    // Released pins show the inverse so a stale bit is never read as good
    #20 if (i_run !== 1'b1)
      {o_pin_a, o_pin_b} = ~{o_pin_a, o_pin_b};
  end
endmodule : link_source_model

/* File: dv/io_cell_ddr_gearing_tb.sv */
`timescale 1ns/10ps
// ************************************************************
// Self-checking bench
// ************************************************************
module io_cell_ddr_gearing_tb;
  logic clk, rst, run, fast_edge_clock, pa, pb, sclk, shclk, top, slip, rden, tick, rxv;
  logic pop, fv, trst, tby2, wen, tout, soe, doe, tick_d;
  logic [1:0] gear, tin;
  logic [2:0] tap;
  logic [6:0] rxw, fw;
  logic [15:0] hist;
  logic [6:0] exp_q[$];
  int err_count, n_compared, nval;

  io_cell_ddr_gearing io_cell_ddr_gearing_inst (.i_clk(clk), .i_sys_rst(rst),
    .i_fast_edge_clock(fast_edge_clock), .i_pin_a(pa), .i_pin_b(pb), .i_strobe_write_clock(sclk),
    .i_shifted_data_write_clock(shclk), .i_cell_top(top), .i_gear_mode(gear),
    .i_delay_tap(tap), .i_align_slip(slip), .i_mem_read_en(rden), .o_sys_tick(tick),
    .o_rx_valid(rxv), .o_rx_word(rxw), .i_fifo_pop(pop), .o_fifo_valid(fv),
    .o_fifo_word(fw), .i_tristate_rst(trst), .i_tristate_by_two(tby2),
    .i_tristate_control_in(tin), .i_mem_write_en(wen), .o_tristate_control_out(tout),
    .o_strobe_oe(soe), .o_data_oe(doe));
  link_source_model link_source_model_inst (.i_run(run), .o_edge_clk(fast_edge_clock), .o_pin_a(pa),
    .o_pin_b(pb), .o_strobe_clk(sclk), .o_shift_clk(shclk), .o_hist(hist));

  // 125 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ************************************************************
  // Expectation and compare helpers
  // ************************************************************
  function automatic logic [2:0] ratio_of(input logic t, input logic [1:0] g);
    if (t || g == 2'h0 || g == 2'h3)
      return io_cell_pkg::RATIO_BY_ONE;
    return (g == 2'h1) ? io_cell_pkg::RATIO_BY_TWO : io_cell_pkg::RATIO_SEVEN;
  endfunction : ratio_of
  task automatic check_word(input string what, input logic [6:0] e, input logic [6:0] s);
    n_compared++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", what, e, s);
      err_count++;
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic e, input logic s);
    check_word(what, {6'h00, e}, {6'h00, s});
  endtask : check_bit
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Each word must be the newest bits sent, newest in bit0, upper bits zero;
  // looked at on the falling edge so the registered outputs have settled
  always @(negedge clk)
  begin
    if (rxv === 1'b1)
    begin
      check_bit("tick before valid", 1'b1, tick_d);
      check_word("rx word", 7'(hist & ((16'h0001 << ratio_of(top, gear)) - 16'h0001)), rxw);
      // Four entries plus the output register hold words; later ones drop
      if (rden && !top && exp_q.size() < io_cell_pkg::FIFO_DEPTH + 1)
        exp_q.push_back(rxw);
      if (!tby2)
        check_bit("ts single", tin[0], tout);
      else if (nval > 0)
        check_bit("ts pair", (ratio_of(top, gear) == io_cell_pkg::RATIO_SEVEN) ? tin[0] : tin[1], tout);
      nval++;
    end
    tick_d = tick;
  end

  // ************************************************************
  // One frame of 28 link edges in a given configuration
  // ************************************************************
  task automatic run_frame(input logic t, input logic [1:0] g, input logic [2:0] tp,
                           input logic sl, input logic rd);
    rst = 1'b1;
    {top, gear, tap, rden} = {t, g, tp, rd};
    {wen, tby2, tin} = 4'($urandom);
    step(4);
    rst = 1'b0;
    step(4);
    slip = sl;
    step(1);
    slip = 1'b0;
    nval = 0;
    exp_q.delete();
    run = 1'b1;
    step(278);
    run = 1'b0;
    step(40);
    check_word("word count", 7'((28 - sl) / ratio_of(t, g)), 7'(nval));
    check_bit("strobe oe", wen, soe);
    check_bit("data oe", wen, doe);
    // Drain under a bound; a word left behind shows as a count mismatch
    for (int k = 0; k < 40 && fv === 1'b1; k++)
    begin
      check_word("fifo word", (exp_q.size() > 0) ? exp_q.pop_front() : ~fw, fw);
      pop = 1'b1;
      step(1);
      pop = 1'b0;
      step(2);
    end
    check_word("fifo left", 7'h00, 7'(exp_q.size()));
    trst = 1'b1;
    step(1);
    trst = 1'b0;
    check_word("ts cleared", 7'h00, {4'h0, tout, soe, doe});
  endtask : run_frame

  // Main sequence: corner frames first, then random ones
  initial
  begin
    {rst, run, top, gear, tap, slip, rden, pop, trst, tby2, tin, wen} = 16'h8000;
    err_count = 0;
    n_compared = 0;
    nval = 0;
    void'($urandom(32'h99ea));
    step(4);
    check_word("init outs", 7'h00, {1'b0, tick, rxv, fv, tout, soe, doe});
    check_word("init words", 7'h00, rxw | fw);
    run_frame(1'b0, 2'h0, 3'h0, 1'b0, 1'b1);
    run_frame(1'b0, 2'h1, 3'h3, 1'b1, 1'b1);
    run_frame(1'b0, 2'h2, 3'h1, 1'b0, 1'b1);
    run_frame(1'b1, 2'h1, 3'h2, 1'b0, 1'b1);
    run_frame(1'b0, 2'h3, 3'h0, 1'b1, 1'b0);
    repeat (4)
      run_frame(1'($urandom), 2'($urandom), 3'($urandom % 4), 1'($urandom), 1'($urandom));
    conclude();
  end

  // Hang guard: a run this long counts as a mismatch
  initial
  begin
    #200000;
    $display("[ERR] run limit expected done seen hang");
    err_count++;
    conclude();
  end
endmodule : io_cell_ddr_gearing_tb
